// [uml_modem_lines.sv]
`timescale 1ns/10ps
`default_nettype none

module uml_modem_lines #(
   parameter int unsigned WAKE_COUNT = uml_pkg::WAKE_CYCLES
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device transmitter side
   input  wire logic        tx_bit_n,
   input  wire logic        tx_active,
   input  wire logic        char_done,
   output logic             tx_allowed,
   // host lines
   input  wire logic        txd_in,
   input  wire logic        rts_in_n,
   input  wire logic        dtr_in_n,
   output logic             rxd_out,
   output logic             cts_out_n,
   output logic             dsr_out_n,
   output logic             dcd_out_n,
   output logic             lines_oe,
   output logic             pull_up_en,
   // port state
   output logic             port_enabled,
   output logic             active_mode,
   output logic             rx_char_valid_n,
   output logic             rxd_sync
);
   import uml_pkg::*;

   typedef struct packed {
      logic [CFG_WIDTH-1:0] cfg;
      logic [2:0]           rts_s;
      logic [2:0]           dtr_s;
      logic [1:0]           txd_s;
      uml_port_type         port;
      logic [24:0]          wake_cnt;
      logic [1:0]           char_cnt;
      logic                 tx_stop;
      logic                 first_lost;
      logic                 booted;
      logic [31:0]          rdata;
      uml_lines_type        lines;
   } uml_state_type;

   uml_state_type state;
   uml_state_type next_state;
   uml_cfg_type   cfg;

   logic rts_on;
   logic dtr_on;
   logic rts_rise;
   logic dtr_rise;
   logic wake_line;
   logic wake_rise;
   logic apb_acc;

   assign cfg       = '{
      flow_control_select:          state.cfg[CFG_FLOW_BIT],
      set_ready_always_on:          state.cfg[CFG_SRAO_BIT],
      carrier_line_always_on:       state.cfg[CFG_CLAO_BIT],
      clear_line_idle_level_config: state.cfg[CFG_CTSOFF_BIT],
      mux_active:                   state.cfg[CFG_MUX_BIT],
      power_saving_config:          state.cfg[CFG_PSV_LSB +: 2],
      data_mode:                    state.cfg[CFG_DATA_BIT],
      carrier_present:              state.cfg[CFG_CARR_BIT],
      voice_established:            state.cfg[CFG_VOICE_BIT]
   };
   assign rts_on    = ~state.rts_s[1];
   assign dtr_on    = ~state.dtr_s[1];
   assign rts_rise  = state.rts_s[2] & ~state.rts_s[1];
   assign dtr_rise  = state.dtr_s[2] & ~state.dtr_s[1];
   assign apb_acc   = psel & penable;

   always_comb begin
      wake_line = 1'b1;
      wake_rise = 1'b0;
      if (cfg.power_saving_config == PSV_RTS && !cfg.flow_control_select) begin
         wake_line = rts_on;
         wake_rise = rts_rise;
      end else if (cfg.power_saving_config == PSV_DTR) begin
         wake_line = dtr_on;
         wake_rise = dtr_rise;
      end
   end

   always_comb begin
      next_state = state;
      // synchronisers: first stage read only by the second
      next_state.rts_s = {state.rts_s[1:0], rts_in_n};
      next_state.dtr_s = {state.dtr_s[1:0], dtr_in_n};
      next_state.txd_s = {state.txd_s[0], txd_in};
      next_state.booted = 1'b1;
      // apb registers
      if (psel && !penable && !pwrite) begin
         if (paddr == CFG_OFFSET) begin
            next_state.rdata = {22'h0, state.cfg};
         end else if (paddr == STATUS_OFFSET) begin
            next_state.rdata = {26'h0, state.first_lost, state.tx_stop,
                                state.port, rts_on, dtr_on};
         end else begin
            next_state.rdata = 32'h0;
         end
      end
      if (apb_acc && pwrite && paddr == CFG_OFFSET) begin
         next_state.cfg = pwdata[CFG_WIDTH-1:0];
      end
      // port enable machine
      case (state.port)
         UML_BOOT: begin
            if (state.booted) begin
               next_state.port = UML_ENABLED;
            end
         end
         UML_OFF: begin
            if (wake_rise) begin
               next_state.port     = UML_WAKING;
               next_state.wake_cnt = 25'(WAKE_COUNT - 1);
            end else if (wake_line) begin
               next_state.port = UML_ENABLED;
            end
         end
         UML_WAKING: begin
            if (!wake_line) begin
               next_state.port = UML_OFF;
            end else if (state.wake_cnt == 25'h0) begin
               next_state.port = UML_ENABLED;
            end else begin
               next_state.wake_cnt = state.wake_cnt - 25'h1;
            end
         end
         default: begin
            if (!wake_line) begin
               next_state.port = UML_OFF;
            end
         end
      endcase
      // first character while waking is not valid
      if (state.port == UML_OFF && wake_rise) begin
         next_state.first_lost = !cfg.flow_control_select &&
                                 cfg.power_saving_config != PSV_OFF;
      end else if (state.port == UML_ENABLED) begin
         next_state.first_lost = 1'b0;
      end
      // transmit stop on request-to-send off
      if (!cfg.flow_control_select || rts_on) begin
         next_state.tx_stop  = 1'b0;
         next_state.char_cnt = 2'h0;
      end else if (tx_active && char_done &&
                   state.char_cnt < 2'(CHAR_LIMIT - 1)) begin
         next_state.char_cnt = state.char_cnt + 2'h1;
      end else begin
         next_state.tx_stop = 1'b1;
      end
      // line outputs
      next_state.lines.pins_oe = (state.port != UML_BOOT);
      next_state.lines.rxd_n   = (tx_active && tx_allowed) ?
                                 tx_bit_n : 1'b1;
      if (state.port == UML_BOOT) begin
         next_state.lines.cts_n = 1'b0;
      end else if (cfg.mux_active) begin
         next_state.lines.cts_n = !active_mode;
      end else if (cfg.flow_control_select) begin
         next_state.lines.cts_n = (state.port != UML_ENABLED);
      end else begin
         next_state.lines.cts_n = cfg.clear_line_idle_level_config;
      end
      if (cfg.set_ready_always_on) begin
         next_state.lines.dsr_n = 1'b0;
      end else begin
         next_state.lines.dsr_n = !cfg.data_mode;
      end
      if (cfg.carrier_line_always_on) begin
         next_state.lines.dcd_n = 1'b0;
      end else begin
         next_state.lines.dcd_n = !(cfg.carrier_present ||
                                    cfg.data_mode ||
                                    cfg.voice_established);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= '0;
         state.cfg      <= CFG_RESET;
         state.rts_s    <= 3'h7;
         state.dtr_s    <= 3'h7;
         state.txd_s    <= 2'h3;
         state.port     <= UML_BOOT;
         state.lines    <= 5'h10 | 5'h0F;
         state.lines.pins_oe <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // outputs
   assign prdata          = state.rdata;
   assign pready          = 1'b1;
   assign pslverr         = 1'b0;
   assign rxd_out         = state.lines.rxd_n;
   assign cts_out_n       = state.lines.cts_n;
   assign dsr_out_n       = state.lines.dsr_n;
   assign dcd_out_n       = state.lines.dcd_n;
   assign lines_oe        = state.lines.pins_oe;
   assign pull_up_en      = 1'b1;
   assign port_enabled    = (state.port == UML_ENABLED);
   assign active_mode     = (state.port != UML_OFF);
   assign rx_char_valid_n = state.first_lost;
   assign rxd_sync        = state.txd_s[1];
   assign tx_allowed      = !state.tx_stop;

   // assertions
   sequence s_rts_drop;
      cfg.flow_control_select && !rts_on && !tx_active;
   endsequence

   property p_stop_on_rts;
      @(posedge pclk) disable iff (!presetn)
      s_rts_drop ##1 (cfg.flow_control_select && !rts_on) |-> ##1 !tx_allowed;
   endproperty
   a_stop_on_rts: assert property (p_stop_on_rts)
      else $error("tx not stopped after rts off");

   property p_cts_flow;
      @(posedge pclk) disable iff (!presetn)
      (state.port != UML_BOOT && cfg.flow_control_select && !cfg.mux_active
       && $stable(state.port) && $stable(state.cfg))
      |=> cts_out_n == !$past(port_enabled);
   endproperty
   a_cts_flow: assert property (p_cts_flow)
      else $error("cts does not follow port state");

   property p_dsr_on;
      @(posedge pclk) disable iff (!presetn)
      cfg.set_ready_always_on && $stable(state.cfg) |=> !dsr_out_n;
   endproperty
   a_dsr_on: assert property (p_dsr_on)
      else $error("dsr not held on");

   property p_dcd_on;
      @(posedge pclk) disable iff (!presetn)
      cfg.carrier_line_always_on && $stable(state.cfg) |=> !dcd_out_n;
   endproperty
   a_dcd_on: assert property (p_dcd_on)
      else $error("dcd not held on");

   property p_dsr_mode;
      @(posedge pclk) disable iff (!presetn)
      !cfg.set_ready_always_on && $stable(state.cfg)
      |=> dsr_out_n == !$past(cfg.data_mode);
   endproperty
   a_dsr_mode: assert property (p_dsr_mode)
      else $error("dsr does not follow data mode");

   property p_dcd_carrier;
      @(posedge pclk) disable iff (!presetn)
      !cfg.carrier_line_always_on && cfg.voice_established
      && $stable(state.cfg) |=> !dcd_out_n;
   endproperty
   a_dcd_carrier: assert property (p_dcd_carrier)
      else $error("dcd off during voice call");

   property p_off_disables;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_ENABLED && !wake_line |=> state.port == UML_OFF;
   endproperty
   a_off_disables: assert property (p_off_disables)
      else $error("port not disabled on line off");

   property p_wake_time;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_WAKING && state.wake_cnt == 25'h0 && wake_line
      |=> port_enabled;
   endproperty
   a_wake_time: assert property (p_wake_time)
      else $error("port not enabled after wake time");

   property p_rxd_idle;
      @(posedge pclk) disable iff (!presetn)
      !tx_active |=> rxd_out;
   endproperty
   a_rxd_idle: assert property (p_rxd_idle)
      else $error("rxd not idle high");

   property p_boot_tristate;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_BOOT |=> !lines_oe;
   endproperty
   a_boot_tristate: assert property (p_boot_tristate)
      else $error("pins driven during boot");

   property p_cts_boot;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_BOOT |=> !cts_out_n;
   endproperty
   a_cts_boot: assert property (p_cts_boot)
      else $error("cts not on at initialisation");

   property p_cts_forced;
      @(posedge pclk) disable iff (!presetn)
      state.port != UML_BOOT && !cfg.mux_active && !cfg.flow_control_select
      |=> cts_out_n == $past(cfg.clear_line_idle_level_config);
   endproperty
   a_cts_forced: assert property (p_cts_forced)
      else $error("cts not at configured idle level");

   property p_cts_mux;
      @(posedge pclk) disable iff (!presetn)
      state.port != UML_BOOT && cfg.mux_active
      |=> cts_out_n == !$past(active_mode);
   endproperty
   a_cts_mux: assert property (p_cts_mux)
      else $error("cts not showing power state");

   property p_char_limit;
      @(posedge pclk) disable iff (!presetn)
      cfg.flow_control_select && !rts_on
      && state.char_cnt == 2'(CHAR_LIMIT - 1) |=> !tx_allowed;
   endproperty
   a_char_limit: assert property (p_char_limit)
      else $error("tx not stopped at character limit");

   property p_wake_enter;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_OFF && wake_rise |=> state.port == UML_WAKING;
   endproperty
   a_wake_enter: assert property (p_wake_enter)
      else $error("no wake on line edge");

   property p_first_lost;
      @(posedge pclk) disable iff (!presetn)
      state.port == UML_OFF && wake_rise && !cfg.flow_control_select
      && cfg.power_saving_config != PSV_OFF |=> rx_char_valid_n;
   endproperty
   a_first_lost: assert property (p_first_lost)
      else $error("first waking character not marked");

   property p_dcd_data;
      @(posedge pclk) disable iff (!presetn)
      !cfg.carrier_line_always_on && cfg.data_mode |=> !dcd_out_n;
   endproperty
   a_dcd_data: assert property (p_dcd_data)
      else $error("dcd off in data mode");

endmodule

`default_nettype wire

// [uml_pkg.sv]
package uml_pkg;

   // clock and wake-up timing
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned WAKE_TIME_MS    = 20;
   localparam int unsigned WAKE_CYCLES     = (CLK_HZ / 1000) * WAKE_TIME_MS;
   localparam int unsigned CHAR_LIMIT      = 2;

   // power-saving configuration codes
   localparam logic [1:0] PSV_OFF   = 2'h0;
   localparam logic [1:0] PSV_CYCLE = 2'h1;
   localparam logic [1:0] PSV_RTS   = 2'h2;
   localparam logic [1:0] PSV_DTR   = 2'h3;

   // APB register offsets
   localparam logic [7:0] CFG_OFFSET    = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // config field positions
   localparam int unsigned CFG_FLOW_BIT   = 0;
   localparam int unsigned CFG_SRAO_BIT   = 1;
   localparam int unsigned CFG_CLAO_BIT   = 2;
   localparam int unsigned CFG_CTSOFF_BIT = 3;
   localparam int unsigned CFG_MUX_BIT    = 4;
   localparam int unsigned CFG_PSV_LSB    = 5;
   localparam int unsigned CFG_DATA_BIT   = 7;
   localparam int unsigned CFG_CARR_BIT   = 8;
   localparam int unsigned CFG_VOICE_BIT  = 9;
   localparam int unsigned CFG_WIDTH      = 10;

   // value after reset: flow control on, both option lines always on
   localparam logic [CFG_WIDTH-1:0] CFG_RESET = 10'h007;

   typedef struct packed {
      logic       flow_control_select;
      logic       set_ready_always_on;
      logic       carrier_line_always_on;
      logic       clear_line_idle_level_config;
      logic       mux_active;
      logic [1:0] power_saving_config;
      logic       data_mode;
      logic       carrier_present;
      logic       voice_established;
   } uml_cfg_type;

   typedef enum logic [1:0] {
      UML_BOOT    = 2'b00,
      UML_OFF     = 2'b01,
      UML_WAKING  = 2'b11,
      UML_ENABLED = 2'b10
   } uml_port_type;

   typedef struct packed {
      logic rxd_n;
      logic cts_n;
      logic dsr_n;
      logic dcd_n;
      logic pins_oe;
   } uml_lines_type;

endpackage

// [uml_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module uml_host_model (
   // clock and pull-up state from the device
   input  wire logic pclk,
   input  wire logic pull_up_en,
   // bench control
   input  wire logic drive_en,
   input  wire logic rts_on,
   input  wire logic dtr_on,
   input  wire logic txd_bit,
   // host pins
   output logic      txd_in,
   output logic      rts_in_n,
   output logic      dtr_in_n
);
   logic last_txd;

   always_ff @(posedge pclk) begin
      last_txd <= txd_in;
   end

   // released pins: pull-up level, else a toggling stand-in
   always_comb begin
      if (drive_en) begin
         txd_in   = txd_bit;
         rts_in_n = ~rts_on;
         dtr_in_n = ~dtr_on;
      end else begin
         txd_in   = pull_up_en ? 1'b1 : ~last_txd;
         rts_in_n = pull_up_en ? 1'b1 : ~last_txd;
         dtr_in_n = pull_up_en ? 1'b1 : ~last_txd;
      end
   end
endmodule

`default_nettype wire

// [uml_modem_lines_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module uml_modem_lines_tb_top;
   import uml_pkg::*;
   localparam logic [3:0] S_CTS = 4'h0, S_DSR = 4'h1, S_DCD = 4'h2;
   localparam logic [3:0] S_RXD = 4'h3, S_TXA = 4'h4, S_PEN = 4'h5;
   localparam logic [3:0] S_OE = 4'h6, S_SYN = 4'h7, S_ERR = 4'h8;
   localparam logic [3:0] S_RD = 4'h9, S_ACT = 4'hA, S_VAL = 4'hB;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, tx_bit_n = 1'b1;
   logic        tx_active = 1'b0, char_done = 1'b0, drive_en = 1'b1;
   logic        rts_on = 1'b1, dtr_on = 1'b1, txd_bit = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, got;
   logic        pready, pslverr, tx_allowed, txd_in, rts_in_n, dtr_in_n;
   logic        rxd_out, cts_out_n, dsr_out_n, dcd_out_n, lines_oe;
   logic        pull_up_en, port_enabled, active_mode, rx_char_valid_n;
   logic        rxd_sync;
   logic [35:0] exp_q[$];
   logic [35:0] note;
   logic [9:0]  cfgs[8] = '{10'h001, 10'h081, 10'h101, 10'h201,
                            10'h006, 10'h00E, 10'h017, 10'h007};
   logic [2:0]  outs[8] = '{3'h3, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4, 3'h0, 3'h0};
   int          errors = 0, total_checks = 0, cycles = 0, seed = 24;

   always #20 pclk = ~pclk;

   uml_modem_lines #(.WAKE_COUNT(8)) i_uml_modem_lines (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_bit_n(tx_bit_n),
      .tx_active(tx_active), .char_done(char_done),
      .tx_allowed(tx_allowed), .txd_in(txd_in), .rts_in_n(rts_in_n),
      .dtr_in_n(dtr_in_n), .rxd_out(rxd_out), .cts_out_n(cts_out_n),
      .dsr_out_n(dsr_out_n), .dcd_out_n(dcd_out_n), .lines_oe(lines_oe),
      .pull_up_en(pull_up_en), .port_enabled(port_enabled),
      .active_mode(active_mode), .rx_char_valid_n(rx_char_valid_n),
      .rxd_sync(rxd_sync));

   uml_host_model i_uml_host_model (
      .pclk(pclk), .pull_up_en(pull_up_en), .drive_en(drive_en),
      .rts_on(rts_on), .dtr_on(dtr_on), .txd_bit(txd_bit),
      .txd_in(txd_in), .rts_in_n(rts_in_n), .dtr_in_n(dtr_in_n));

   function automatic logic [31:0] obs(input logic [3:0] s);
      logic [11:0] lv;
      lv = {rx_char_valid_n, active_mode, 1'b0,
            pslverr, rxd_sync, lines_oe, port_enabled, tx_allowed,
            rxd_out, dcd_out_n, dsr_out_n, cts_out_n};
      obs = (s == S_RD) ? prdata : {31'h0, lv[s]};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // wait up to n cycles, then note the expectation
   task automatic chk(input logic [3:0] s, input logic [31:0] e,
                      input int n);
      repeat (n) begin
         @(negedge pclk);
         if (obs(s) === e) break;
      end
      exp_q.push_back({s, e});
      @(posedge pclk);
   endtask

   task automatic fin(input string name);
      $display("test %s done", name);
   endtask

   task automatic report_and_stop;
      @(negedge pclk);
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watcher: compare every queued note against settled outputs
   always @(posedge pclk) begin
      while (exp_q.size() > 0) begin
         note = exp_q.pop_front();
         got  = obs(note[35:32]);
         total_checks++;
         if (got !== note[31:0]) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, note[31:0], got);
         end
      end
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      chk(S_OE, 32'h0, 1);
      cyc(3);
      presetn <= 1'b1;
      chk(S_OE, 32'h1, 4);
      chk(S_CTS, 32'h0, 4);
      chk(S_RXD, 32'h1, 1);
      chk(S_DSR, 32'h0, 1);
      chk(S_DCD, 32'h0, 1);
      chk(S_PEN, 32'h1, 1);
      apb(1'b0, CFG_OFFSET, 32'h0);
      chk(S_RD, {22'h0, CFG_RESET}, 1);
      apb(1'b1, 8'h08, 32'hFFFFFFFF);
      apb(1'b0, 8'h08, 32'h0);
      chk(S_RD, 32'h0, 1);
      chk(S_ERR, 32'h0, 1);
      fin("reset");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, CFG_OFFSET, {22'h0, cfgs[i]});
         apb(1'b0, CFG_OFFSET, 32'h0);
         chk(S_RD, {22'h0, cfgs[i]}, 1);
         chk(S_DSR, {31'h0, outs[i][0]}, 4);
         chk(S_DCD, {31'h0, outs[i][1]}, 4);
         chk(S_CTS, {31'h0, outs[i][2]}, 4);
      end
      fin("options");
      tx_active <= 1'b1;
      repeat (4) begin
         tx_bit_n <= 1'($random(seed));
         cyc(1);
         chk(S_RXD, {31'h0, tx_bit_n}, 4);
      end
      chk(S_TXA, 32'h1, 1);
      rts_on <= 1'b0;
      repeat (2) begin
         cyc(3);
         char_done <= 1'b1;
         cyc(1);
         char_done <= 1'b0;
      end
      chk(S_TXA, 32'h0, 4);
      rts_on <= 1'b1;
      chk(S_TXA, 32'h1, 8);
      tx_active <= 1'b0;
      chk(S_RXD, 32'h1, 4);
      fin("flow");
      apb(1'b1, CFG_OFFSET, 32'h046);
      rts_on <= 1'b0;
      chk(S_PEN, 32'h0, 6);
      chk(S_ACT, 32'h0, 1);
      rts_on <= 1'b1;
      cyc(4);
      chk(S_PEN, 32'h0, 1);
      chk(S_VAL, 32'h1, 1);
      chk(S_PEN, 32'h1, 16);
      apb(1'b1, CFG_OFFSET, 32'h067);
      dtr_on <= 1'b0;
      chk(S_PEN, 32'h0, 6);
      chk(S_CTS, 32'h1, 2);
      dtr_on <= 1'b1;
      chk(S_PEN, 32'h1, 16);
      chk(S_CTS, 32'h0, 2);
      fin("wake");
      apb(1'b1, CFG_OFFSET, 32'h007);
      drive_en <= 1'b0;
      cyc(4);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(S_RD, 32'h18, 1);
      chk(S_SYN, 32'h1, 4);
      fin("pull_up");
      report_and_stop();
   end
endmodule

`default_nettype wire
